// file: verilog/sdram_timing_consts.svh
// timing counts, mode fields and reset values of the sdram command block
`ifndef SDRAM_TIMING_CONSTS_SVH
`define SDRAM_TIMING_CONSTS_SVH
`define CLK_NS 10
`define CEIL_CYC(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define T_RC_NS 60
`define T_RAS_MIN_NS 42
`define T_RAS_MAX_NS 100000
`define T_RP_NS 18
`define T_RCD_NS 18
`define T_RRD_NS 12
`define T_REF_MS 64
`define POWER_UP_US 200
`define T_RC_CYC `CEIL_CYC(`T_RC_NS)
`define T_RAS_MIN_CYC `CEIL_CYC(`T_RAS_MIN_NS)
`define T_RAS_MAX_CYC (`T_RAS_MAX_NS / `CLK_NS)
`define T_RP_CYC `CEIL_CYC(`T_RP_NS)
`define T_RCD_CYC `CEIL_CYC(`T_RCD_NS)
`define T_RRD_CYC `CEIL_CYC(`T_RRD_NS)
`define T_REF_CYC (`T_REF_MS * 1000000 / `CLK_NS)
`define POWER_UP_CYC (`POWER_UP_US * 1000 / `CLK_NS)
`define REFRESH_COUNT 13'h1000
`define WR_AP_RECOVERY_CYC 5
`define WR_PRE_GAP_CYC 2
`define MODE_LOAD_CYC 2
`define SAT_COUNT 14'h3fff
`define MODE_RESET 12'h020
`define MODE_BL_MSB 2
`define MODE_BT_BIT 3
`define MODE_CL_LSB 4
`define MODE_CL_MSB 6
`define CL_THREE 3'h3
`define BL_FULL 3'h7
`define AUTO_PRE_BIT 10
`endif

// file: verilog/sdram_timing_pkg.sv
// types shared by the sdram command timing block
package sdram_timing_pkg;
	typedef logic [11:0] addr_t;
	typedef logic [15:0] word_t;
	// command code is {row strobe, column strobe, write enable}
	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR = 3'h4,
		CMD_RD = 3'h5,
		CMD_STOP = 3'h6,
		CMD_NOP = 3'h7
	} cmd_e;
	typedef enum {IDLE, READING, WRITING} burst_e;
endpackage

// file: verilog/bank_timer.sv
// one bank: open row register and same-bank interval checks
`timescale 1ns/1ps
`include "sdram_timing_consts.svh"
module bank_timer #(
	parameter logic [13:0] RAS_MAX_CYCLES = 14'h2710
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic open_cmd,
	input wire logic close_cmd,
	input wire logic col_cmd,
	input wire logic refresh_cmd,
	input wire sdram_timing_pkg::addr_t row_in,
	output sdram_timing_pkg::addr_t row,
	output logic fault
);
	import sdram_timing_pkg::*;
	logic is_open;
	logic [13:0] since_act;
	logic [13:0] since_pre;

	// row registered by activate, held until the next activate
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			is_open <= 1'b0;
			row <= '0;
		end else if (open_cmd) begin
			is_open <= 1'b1;
			row <= row_in; // see RULE19
		end else if (close_cmd) begin
			is_open <= 1'b0;
		end
	end

	// saturating cycle counts since the last activate or refresh and since the last precharge
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			since_act <= `SAT_COUNT;
			since_pre <= `SAT_COUNT;
		end else begin
			if (open_cmd || refresh_cmd)
				since_act <= 14'h1;
			else if (since_act != `SAT_COUNT)
				since_act <= since_act + 14'h1;
			if (close_cmd)
				since_pre <= 14'h1;
			else if (since_pre != `SAT_COUNT)
				since_pre <= since_pre + 14'h1;
		end
	end

	// flag a command that arrives too early or a row left open too long
	always_comb begin
		fault = 1'b0;
		if ((open_cmd || refresh_cmd) && since_act < 14'(`T_RC_CYC))
			fault = 1'b1; // see RULE1
		if (close_cmd && is_open && since_act < 14'(`T_RAS_MIN_CYC))
			fault = 1'b1; // see RULE2
		if (is_open && since_act == RAS_MAX_CYCLES)
			fault = 1'b1; // see RULE2
		if (open_cmd && since_pre < 14'(`T_RP_CYC))
			fault = 1'b1; // see RULE3
		if (col_cmd && since_act < 14'(`T_RCD_CYC))
			fault = 1'b1; // see RULE4
	end
endmodule

// file: verilog/sdram_command_timing.sv
// sdram device side: command decode, bursts, masks, timing monitor
`timescale 1ns/1ps
`include "sdram_timing_consts.svh"
// Summary of operation
// RULE1: same-bank activates or refreshes need row cycle
// RULE2: activate to precharge between minimum and maximum
// RULE3: precharge to activate needs precharge time
// RULE4: activate to first column command delay
// RULE5: activates to different banks need spacing
// RULE6: all rows refreshed within each window
// RULE7: auto-precharge write recovery before activate
// RULE8: precharge two cycles after last write
// RULE9: column commands accepted every cycle
// RULE10: clock gate low suspends after one
// RULE11: clock gate high resumes after one
// RULE12: write byte masks act with zero delay
// RULE13: read byte masks float data after two
// RULE14: first write word with write command
// RULE15: burst stop one cycle after write
// RULE16: new column command after last write
// RULE17: mode load needs two cycles before activate
// RULE18: power-up wait before any operation
// RULE19: activate opens row, column command picks column
// RULE20: read latency from mode register field
// RULE21: controller rounds up, times banks separately
module sdram_command_timing #(
	parameter logic [13:0] RAS_MAX_CYCLES = 14'(`T_RAS_MAX_CYC),
	parameter logic [22:0] REF_WINDOW_CYCLES = 23'(`T_REF_CYC),
	parameter logic [14:0] POWER_UP_CYCLES = 15'(`POWER_UP_CYC)
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	input wire logic clock_gate,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire sdram_timing_pkg::addr_t addr,
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	input wire sdram_timing_pkg::word_t dq_in,
	output sdram_timing_pkg::word_t dq_out,
	output logic [1:0] dq_oe,
	output logic store_write,
	output logic store_read,
	output logic [1:0] store_bank,
	output sdram_timing_pkg::addr_t store_row,
	output logic [7:0] store_col,
	output sdram_timing_pkg::word_t store_data,
	output logic [1:0] store_byte_en,
	input wire sdram_timing_pkg::word_t load_data,
	output logic timing_fault
);
	import sdram_timing_pkg::*;
	logic live;
	cmd_e cmd;
	logic [1:0] bank;
	logic [1:0] masks;
	addr_t mode;
	logic cas_lat3;
	logic full_page;
	logic [7:0] blen_mask;
	burst_e state;
	logic [1:0] bbank;
	logic [7:0] bstart;
	logic [7:0] bcnt;
	logic [7:0] bleft;
	logic word_now;
	logic col_cmd;
	addr_t rows [4];
	logic [3:0] bank_fault;
	logic [1:0] mask_d;
	logic stage_valid;
	word_t stage_data;
	logic [13:0] since_any_act;
	logic [13:0] since_lmr;
	logic [13:0] wr_gap;
	logic ap_write;
	logic [22:0] ref_window;
	logic [12:0] ref_count;
	logic [14:0] pu_count;
	logic pu_done;
	logic next_fault;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	function automatic logic [7:0] burst_col(input logic [7:0] s,
		input logic [7:0] c, input logic [7:0] m, input logic il);
		logic [7:0] off;
		off = il ? (s ^ c) : 8'(s + c);
		return (s & ~m) | (off & m);
	endfunction

	// internal clock follows the gate pin one cycle late
	always_ff @(posedge clk_sys) begin
		if (reset)
			live <= 1'b1;
		else
			live <= clock_gate; // see RULE10 RULE11
	end

	// decode; suspended cycles and deselect read as no operation
	assign bank = {bank_select_high, bank_select_low};
	assign masks = {high_byte_mask, low_byte_mask};
	assign cmd = (live && !chip_select_n) ?
		cmd_e'({row_strobe_n, col_strobe_n, write_enable_n}) : CMD_NOP;
	assign col_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);

	// mode register holds burst length, type and read latency
	always_ff @(posedge clk_sys) begin
		if (reset)
			mode <= `MODE_RESET;
		else if (cmd == CMD_LMR)
			mode <= addr; // see RULE20
	end
	assign cas_lat3 = mode[`MODE_CL_MSB:`MODE_CL_LSB] == `CL_THREE;
	assign full_page = mode[`MODE_BL_MSB:0] == `BL_FULL;

	// burst length code to column wrap mask
	always_comb begin
		case (mode[`MODE_BL_MSB:0])
		3'h0: blen_mask = 8'h00;
		3'h1: blen_mask = 8'h01;
		3'h2: blen_mask = 8'h03;
		3'h3: blen_mask = 8'h07;
		`BL_FULL: blen_mask = 8'hff;
		default: blen_mask = 8'h00;
		endcase
	end

	assign word_now = live && (state != IDLE) && !col_cmd &&
		(cmd != CMD_STOP) && (cmd != CMD_PRE);

	// burst engine; a new column command cuts the running burst
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= IDLE;
			bbank <= 2'h0;
			bstart <= 8'h0;
			bcnt <= 8'h0;
			bleft <= 8'h0;
		end else if (col_cmd) begin // see RULE9 RULE16
			if (blen_mask == 8'h00)
				state <= IDLE;
			else
				state <= (cmd == CMD_RD) ? READING : WRITING;
			bbank <= bank;
			bstart <= addr[7:0];
			bcnt <= 8'h1;
			bleft <= blen_mask;
		end else if (cmd == CMD_STOP || cmd == CMD_PRE) begin
			state <= IDLE; // see RULE15
		end else if (word_now) begin
			bcnt <= bcnt + 8'h1;
			bleft <= bleft - 8'h1;
			if (bleft == 8'h1 && !full_page)
				state <= IDLE;
		end
	end

	// storage port: one word each cycle, write data taken with command
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			store_write <= 1'b0;
			store_read <= 1'b0;
			store_bank <= 2'h0;
			store_row <= '0;
			store_col <= 8'h0;
			store_data <= '0;
			store_byte_en <= 2'h0;
		end else begin
			store_write <= (cmd == CMD_WR) || (word_now && state == WRITING);
			store_read <= (cmd == CMD_RD) || (word_now && state == READING);
			store_data <= dq_in; // see RULE14
			store_byte_en <= ~masks; // see RULE12
			if (col_cmd) begin
				store_bank <= bank;
				store_row <= rows[bank]; // see RULE19
				store_col <= addr[7:0];
			end else begin
				store_bank <= bbank;
				store_row <= rows[bbank];
				store_col <= burst_col(bstart, bcnt, blen_mask,
					mode[`MODE_BT_BIT]);
			end
		end
	end

	// read pipeline: one extra stage when latency is three
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stage_valid <= 1'b0;
			stage_data <= '0;
			mask_d <= 2'h0;
		end else begin
			stage_valid <= store_read;
			stage_data <= load_data;
			mask_d <= masks;
		end
	end

	// per byte lane output drivers; read mask reaches the pins two later
	generate
		for (genvar i = 0; i < 2; i++) begin : g_lane
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					dq_out[8*i +: 8] <= 8'h0;
					dq_oe[i] <= 1'b0;
				end else begin
					dq_out[8*i +: 8] <= cas_lat3 ? stage_data[8*i +: 8] :
						load_data[8*i +: 8]; // see RULE20
					dq_oe[i] <= (cas_lat3 ? stage_valid : store_read) &&
						!mask_d[i]; // see RULE13
				end
			end
		end
	endgenerate

	// per bank row registers and same-bank interval checks
	generate
		for (genvar b = 0; b < 4; b++) begin : g_bank
			bank_timer #(.RAS_MAX_CYCLES(RAS_MAX_CYCLES)) u_bank (
				.clk_sys(clk_sys),
				.reset(reset),
				.open_cmd(cmd == CMD_ACT && bank == 2'(b)),
				.close_cmd(cmd == CMD_PRE &&
					(bank == 2'(b) || addr[`AUTO_PRE_BIT])),
				.col_cmd(col_cmd && bank == 2'(b)),
				.refresh_cmd(cmd == CMD_REF),
				.row_in(addr),
				.row(rows[b]),
				.fault(bank_fault[b])
			);
		end
	endgenerate

	// cross-bank, mode load and write recovery interval counters
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			since_any_act <= `SAT_COUNT;
			since_lmr <= `SAT_COUNT;
			wr_gap <= `SAT_COUNT;
			ap_write <= 1'b0;
		end else begin
			since_any_act <= (cmd == CMD_ACT) ? 14'h1 :
				(since_any_act == `SAT_COUNT ? since_any_act :
				since_any_act + 14'h1);
			since_lmr <= (cmd == CMD_LMR) ? 14'h1 :
				(since_lmr == `SAT_COUNT ? since_lmr : since_lmr + 14'h1);
			if (cmd == CMD_WR || (word_now && state == WRITING))
				wr_gap <= 14'h1;
			else if (wr_gap != `SAT_COUNT)
				wr_gap <= wr_gap + 14'h1;
			if (cmd == CMD_WR)
				ap_write <= addr[`AUTO_PRE_BIT];
			else if (cmd == CMD_RD)
				ap_write <= 1'b0;
		end
	end

	// power-up wait and refresh rate bookkeeping
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pu_count <= 15'h0;
			pu_done <= 1'b0;
			ref_window <= 23'h0;
			ref_count <= 13'h0;
		end else if (!pu_done) begin
			pu_count <= pu_count + 15'h1;
			pu_done <= (pu_count + 15'h1) >= POWER_UP_CYCLES;
		end else if (ref_window == REF_WINDOW_CYCLES - 23'h1) begin
			ref_window <= 23'h0;
			ref_count <= 13'h0;
		end else begin
			ref_window <= ref_window + 23'h1;
			if (cmd == CMD_REF && ref_count != `REFRESH_COUNT)
				ref_count <= ref_count + 13'h1;
		end
	end

	// collect every timing violation into one fault pulse
	always_comb begin
		next_fault = |bank_fault; // see RULE1 RULE2 RULE3 RULE4 RULE21
		if (cmd == CMD_ACT && since_any_act < 14'(`T_RRD_CYC))
			next_fault = 1'b1; // see RULE5
		// a refresh in the window's last cycle still counts for it
		if (pu_done && ref_window == REF_WINDOW_CYCLES - 23'h1 &&
			ref_count + 13'(cmd == CMD_REF) < `REFRESH_COUNT)
			next_fault = 1'b1; // see RULE6
		if ((cmd == CMD_ACT || cmd == CMD_REF) && ap_write &&
			wr_gap < 14'(`WR_AP_RECOVERY_CYC))
			next_fault = 1'b1; // see RULE7
		if (cmd == CMD_PRE && wr_gap < 14'(`WR_PRE_GAP_CYC))
			next_fault = 1'b1; // see RULE8
		if ((cmd == CMD_ACT || cmd == CMD_REF) &&
			since_lmr < 14'(`MODE_LOAD_CYC))
			next_fault = 1'b1; // see RULE17
		if (!pu_done && cmd != CMD_NOP)
			next_fault = 1'b1; // see RULE18
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			timing_fault <= 1'b0;
		else
			timing_fault <= next_fault;
	end

	// checks and coverage
	chk_gate_entry: assert property (!clock_gate ##1 (!chip_select_n &&
		row_strobe_n && !col_strobe_n && !write_enable_n) |=>
		!store_write) else $error("write taken while suspended"); // see RULE10
	chk_gate_exit: assert property (clock_gate ##1 (!chip_select_n &&
		row_strobe_n && !col_strobe_n && !write_enable_n) |=>
		store_write) else $error("write lost after resume"); // see RULE11
	chk_write_mask: assert property (cmd == CMD_WR |=>
		store_byte_en == ~$past(masks)) else $error("write mask late"); // see RULE12
	chk_read_mask: assert property (dq_oe[0] |->
		!$past(low_byte_mask, 2)) else $error("read mask delay wrong"); // see RULE13
	chk_write_data: assert property (cmd == CMD_WR |=> store_write &&
		store_data == $past(dq_in)) else $error("first word missed"); // see RULE14
	chk_column_rate: assert property (cmd == CMD_RD |=> store_read &&
		store_col == $past(addr[7:0])) else $error("column not taken"); // see RULE9
	chk_row_select: assert property (cmd == CMD_ACT ##1 (col_cmd &&
		$past(bank) == bank) |=> store_row == $past(addr, 2))
		else $error("wrong row"); // see RULE19
	chk_latency_two: assert property (cmd == CMD_RD && !cas_lat3 &&
		!low_byte_mask |-> ##2 dq_oe[0])
		else $error("latency two data missing"); // see RULE20
	chk_latency_three: assert property (cmd == CMD_RD && cas_lat3
		##1 !low_byte_mask |-> ##2 dq_oe[0])
		else $error("latency three data missing"); // see RULE20
	chk_mode_load: assert property (cmd == CMD_LMR |=> cas_lat3 ==
		($past(addr[6:4]) == `CL_THREE)) else $error("mode not loaded"); // see RULE20
	cov_read_cl3: cover property (cmd == CMD_RD && cas_lat3 ##3 dq_oe[1]);
	cov_write_burst: cover property (cmd == CMD_WR ##1 store_write ##1
		store_write);
	cov_suspend: cover property (state != IDLE && !live);
	cov_fault: cover property (timing_fault);
endmodule

// file: testbench/sdram_ctrl_model.sv
// controller model driving sdram command, mask and data pins
`timescale 1ns/1ps
module sdram_ctrl_model (
	input wire logic clk_sys,
	output logic chip_select_n,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_enable_n,
	output logic clock_gate,
	output logic bank_select_low,
	output logic bank_select_high,
	output sdram_timing_pkg::addr_t addr,
	output logic low_byte_mask,
	output logic high_byte_mask,
	output sdram_timing_pkg::word_t dq_in,
	output logic want_fault
);
	import sdram_timing_pkg::*;
	// idle pins at time zero: no operation, masks high, gate on
	initial begin
		chip_select_n = 1'b0;
		{row_strobe_n, col_strobe_n, write_enable_n} = CMD_NOP;
		clock_gate = 1'b1;
		{bank_select_high, bank_select_low} = 2'h0;
		addr = 12'h000;
		{high_byte_mask, low_byte_mask} = 2'h3;
		dq_in = 16'h0000;
		want_fault = 1'b0;
	end
	// one command slot, launched just after a rising edge
	task automatic issue(input cmd_e c, input logic [1:0] b,
			input addr_t a, input word_t d, input logic [1:0] m,
			input logic g, input logic f);
		@(posedge clk_sys);
		chip_select_n <= 1'b0;
		{row_strobe_n, col_strobe_n, write_enable_n} <= c;
		{bank_select_high, bank_select_low} <= b;
		addr <= a;
		{high_byte_mask, low_byte_mask} <= m;
		clock_gate <= g;
		want_fault <= f;
		// data rides with the write, otherwise the bus wanders
		dq_in <= (c == CMD_WR) ? d : ~dq_in;
	endtask
	// one deselected slot; command pins keep their last value
	task automatic deselect(input word_t d);
		@(posedge clk_sys);
		chip_select_n <= 1'b1;
		want_fault <= 1'b0;
		dq_in <= d;
	endtask
endmodule

// file: testbench/tb_sdram_command_timing.sv
// self-checking bench for the sdram command timing block
`timescale 1ns/1ps
module tb_sdram_command_timing;
	import sdram_timing_pkg::*;
	logic clk_sys, reset, chip_select_n, row_strobe_n, col_strobe_n;
	logic write_enable_n, clock_gate, bank_select_low, bank_select_high;
	logic low_byte_mask, high_byte_mask, want_fault, timing_fault;
	logic store_write, store_read;
	logic [1:0] dq_oe, store_bank, store_byte_en;
	logic [7:0] store_col;
	addr_t addr, store_row, row;
	word_t dq_in, dq_out, store_data, load_data;
	logic f1 = 1'b0;
	int n_errors = 0;
	int comparisons = 0;
	logic [31:0] seed = 32'hfcfb;
	logic [7:0] col [0:7];
	word_t dat [0:7];
	logic [1:0] msk [0:7];
	// gaps in whole cycles, rounded up from the ns minimum
	typedef struct packed {cmd_e c1; cmd_e c2; logic [1:0] b2; addr_t a1;
		int gap; logic open;} pair_s;
	pair_s pairs [0:7] = '{
		'{CMD_ACT, CMD_WR, 2'h0, 12'h000, 2, 1'b0},
		'{CMD_ACT, CMD_ACT, 2'h1, 12'h000, 2, 1'b0},
		'{CMD_PRE, CMD_ACT, 2'h0, 12'h000, 2, 1'b0},
		'{CMD_ACT, CMD_PRE, 2'h0, 12'h000, 5, 1'b0},
		'{CMD_REF, CMD_REF, 2'h0, 12'h000, 6, 1'b0},
		'{CMD_LMR, CMD_ACT, 2'h0, 12'h020, 2, 1'b0},
		'{CMD_WR, CMD_PRE, 2'h0, 12'h000, 2, 1'b1},
		'{CMD_WR, CMD_REF, 2'h0, 12'h400, 5, 1'b1}
	};
	// 100 MHz clock
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	// backing store answers with a word made from its address
	assign load_data = {store_col, store_row[5:0], store_bank} ^ 16'ha5c3;
	sdram_command_timing #(
		.RAS_MAX_CYCLES(14'h0032),
		.REF_WINDOW_CYCLES(23'h7fffff),
		.POWER_UP_CYCLES(15'h0014)
	) sdram_command_timing_i (
		.clk_sys(clk_sys), .reset(reset), .chip_select_n(chip_select_n),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_enable_n(write_enable_n), .clock_gate(clock_gate),
		.bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high), .addr(addr),
		.low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.store_write(store_write), .store_read(store_read),
		.store_bank(store_bank), .store_row(store_row),
		.store_col(store_col), .store_data(store_data),
		.store_byte_en(store_byte_en), .load_data(load_data),
		.timing_fault(timing_fault)
	);
	sdram_ctrl_model sdram_ctrl_model_i (
		.clk_sys(clk_sys), .chip_select_n(chip_select_n),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_enable_n(write_enable_n), .clock_gate(clock_gate),
		.bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high), .addr(addr),
		.low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask),
		.dq_in(dq_in), .want_fault(want_fault)
	);
	function automatic word_t ram_word(input logic [1:0] b, input addr_t r,
			input logic [7:0] c);
		return {c, r[5:0], b} ^ 16'ha5c3;
	endfunction
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h00400007 : 32'h0);
		return seed;
	endfunction
	// interleaved burst order within a block of four
	function automatic logic [7:0] ilv_col(input logic [7:0] s,
			input int k);
		return {s[7:2], s[1:0] ^ k[1:0]};
	endfunction
	// one burst word, checked one slot after its own slot
	task automatic sw(input logic w, input logic [7:0] c, input word_t d);
		#1;
		chk("burst write", {31'h0, w}, 32'(store_write));
		if (w) begin
			chk("burst col", 32'(c), 32'(store_col));
			chk("burst data", 32'(d), 32'(store_data));
		end
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic op(input cmd_e c, input logic [1:0] b, input addr_t a,
			input logic f);
		sdram_ctrl_model_i.issue(c, b, a, 16'h0000, 2'h0, 1'b1, f);
	endtask
	task automatic idle(input int n);
		repeat (n) op(CMD_NOP, 2'h0, 12'h000, 1'b0);
	endtask
	task automatic gw(input cmd_e c, input logic g);
		sdram_ctrl_model_i.issue(c, 2'h1, 12'h000, 16'h1234, 2'h0, g, 1'b0);
	endtask
	// back-to-back writes, each store checked one slot later
	task automatic writes(input logic [1:0] b);
		logic [31:0] r;
		for (int i = 0; i <= 6; i++) begin
			r = rnd();
			col[i] = (i == 5) ? 8'hff : r[7:0];
			dat[i] = r[23:8];
			msk[i] = r[25:24];
			if (i < 6) sdram_ctrl_model_i.issue(CMD_WR, b, {4'h0, col[i]},
				dat[i], msk[i], 1'b1, 1'b0);
			else idle(1);
			#1;
			if (i > 0) begin
				chk("store_write", 32'h1, 32'(store_write));
				chk("store_bank", 32'(b), 32'(store_bank));
				chk("store_row", 32'(row), 32'(store_row));
				chk("store_col", 32'(col[i-1]), 32'(store_col));
				chk("store_data", 32'(dat[i-1]), 32'(store_data));
				chk("byte_en", {30'h0, ~msk[i-1]}, 32'(store_byte_en));
			end
		end
	endtask
	// back-to-back reads; the lane float trails its mask by two edges
	task automatic reads(input logic [1:0] b, input int lat);
		logic [15:0] lane;
		msk[6] = 2'h0;
		msk[7] = 2'h0;
		for (int i = 0; i <= 5 + lat; i++) begin
			if (i < 6) sdram_ctrl_model_i.issue(CMD_RD, b, {4'h0, col[i]},
				16'h0000, msk[i], 1'b1, 1'b0);
			else idle(1);
			#1;
			if (i > 0 && i < 7) begin
				chk("store_read", 32'h1, 32'(store_read));
				chk("rd store_col", 32'(col[i-1]), 32'(store_col));
			end
			if (i >= lat) begin
				lane = {{8{~msk[i-2][1]}}, {8{~msk[i-2][0]}}};
				chk("dq_oe", {30'h0, ~msk[i-2]}, 32'(dq_oe));
				chk("dq_out", 32'(ram_word(b, row, col[i-lat]) & lane),
					32'(dq_out & lane));
			end
		end
		idle(1);
		#1;
		chk("dq_oe idle", 32'h0, 32'(dq_oe));
	endtask
	// want_fault rides with its command; the pulse follows one edge later
	always @(posedge clk_sys) begin
		f1 <= want_fault;
	end
	always @(negedge clk_sys) begin
		if (!reset)
			chk("timing_fault", 32'(f1), 32'(timing_fault));
	end
	// watchdog cuts a hang short
	initial begin
		#50000;
		n_errors++;
		$display("ERROR watchdog expected finish seen hang");
		tally_and_finish;
	end
	// main sequence
	initial begin
		logic [31:0] r;
		reset = 1'b1;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		chk("dq_oe reset", 32'h0, 32'(dq_oe));
		op(CMD_PRE, 2'h0, 12'h400, 1'b1);
		idle(25);
		op(CMD_PRE, 2'h0, 12'h400, 1'b0);
		idle(2);
		op(CMD_REF, 2'h0, 12'h000, 1'b0);
		idle(6);
		op(CMD_REF, 2'h0, 12'h000, 1'b0);
		idle(6);
		op(CMD_LMR, 2'h0, 12'h020, 1'b0);
		idle(2);
		foreach (pairs[i]) begin
			for (int g = pairs[i].gap - 1; g <= pairs[i].gap; g++) begin
				if (pairs[i].open) begin
					op(CMD_ACT, 2'h0, 12'h000, 1'b0);
					idle(7);
				end
				op(pairs[i].c1, 2'h0, pairs[i].a1, 1'b0);
				idle(g - 1);
				op(pairs[i].c2, pairs[i].b2, 12'h000, g < pairs[i].gap);
				idle(7);
				op(CMD_PRE, 2'h0, 12'h400, 1'b0);
				idle(7);
			end
		end
		r = rnd();
		row = r[11:0];
		op(CMD_ACT, 2'h1, row, 1'b0);
		idle(2);
		gw(CMD_NOP, 1'b0);
		gw(CMD_WR, 1'b0);
		gw(CMD_WR, 1'b1);
		#1;
		chk("gated write", 32'h0, 32'(store_write));
		gw(CMD_WR, 1'b1);
		#1;
		chk("resume write", 32'h0, 32'(store_write));
		idle(1);
		#1;
		chk("live write", 32'h1, 32'(store_write));
		writes(2'h1);
		reads(2'h1, 2);
		op(CMD_PRE, 2'h0, 12'h400, 1'b0);
		idle(3);
		op(CMD_LMR, 2'h0, 12'h030, 1'b0);
		idle(2);
		op(CMD_ACT, 2'h2, row, 1'b0);
		idle(2);
		reads(2'h2, 3);
		// burst four, interleaved: deselect, stop and cut mid-burst
		op(CMD_PRE, 2'h0, 12'h400, 1'b0);
		idle(1);
		op(CMD_LMR, 2'h0, 12'h02a, 1'b0);
		idle(2);
		op(CMD_ACT, 2'h3, row, 1'b0);
		idle(2);
		r = rnd();
		sdram_ctrl_model_i.issue(CMD_WR, 2'h3, 12'h005, r[15:0], 2'h0,
			1'b1, 1'b0);
		sdram_ctrl_model_i.deselect(r[31:16]);
		sw(1'b1, 8'h05, r[15:0]);
		op(CMD_NOP, 2'h0, 12'h000, 1'b0);
		sw(1'b1, ilv_col(8'h05, 1), r[31:16]);
		op(CMD_STOP, 2'h0, 12'h000, 1'b0);
		sw(1'b1, ilv_col(8'h05, 2), ~r[31:16]);
		r = rnd();
		sdram_ctrl_model_i.issue(CMD_WR, 2'h3, 12'h002, r[15:0], 2'h0,
			1'b1, 1'b0);
		sw(1'b0, 8'h00, 16'h0000);
		sdram_ctrl_model_i.issue(CMD_WR, 2'h3, 12'h00e, r[31:16], 2'h0,
			1'b1, 1'b0);
		sw(1'b1, 8'h02, r[15:0]);
		for (int k = 0; k <= 4; k++) begin
			op(CMD_NOP, 2'h0, 12'h000, 1'b0);
			sw(k < 4, ilv_col(8'h0e, k),
				k[0] ? ~r[31:16] : r[31:16]);
		end
		idle(4);
		tally_and_finish;
	end
endmodule
